/* File: rtl/bssr_responder.sv */
// boot serial responder: matching bytes, flash sum and identification commands
// assumes a byte framer that measures baud on the first byte and holds rxValid
// until taken; bytes to send leave through a 16-entry fifo
//
// Notes on behaviour
// R1 - first byte 0x86 or 0x30 with valid baud is echoed back
// R2 - second byte 0x79 or 0xCF echoed; a wrong one gets no answer
// R3 - every byte after the first uses the baud measured on the first
// R4 - sum command 0x90 is not echoed; its answer starts once the flash walk ends
// R5 - a bad command byte sends one error code three times, then idles
// R6 - sum status byte 0xAA if all covered bytes are 0xFF, else 0x55
// R7 - status is followed by sum high then low byte, neither on error
// R8 - after the sum answer, wait for the next command byte
// R9 - flash security or password failure stops talk until reset
// R10 - link error during password address or string stops talk until reset
// R11 - id command 0xC0 is echoed, or triple error code and idle
// R12 - id answer opens with 0x3A then count byte 0x13
// R13 - then address length 0x03 and reserved 0xFD, 0x00, 0x00, 0x00
// R14 - then flash size code 0x80 and block count 0x01
// R15 - then writable flash start address 0x00, 0x80, 0x00
// R16 - then flash end 0x00FFFF, ram start 0x000060, ram end 0x00083F
// R17 - last byte is two's complement of the sum of length through ram end
// R18 - after the id checksum, wait for the next command byte
// R19 - flash sum is a 16-bit byte sum sent high then low
`timescale 1ns/100ps
module bssr_responder
	import bssr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	input wire logic rxBaudOk,
	input wire logic rxCommErr,
	input wire logic rxOverrun,
	output logic rxReady,
	output logic baudLock,
	output logic txValid,
	output logic [7:0] txData,
	input wire logic txReady,
	input wire logic flashSecure,
	input wire logic pwPhase,
	input wire logic pwFail,
	output logic [15:0] flashRdAddr,
	output logic flashRdEn,
	input wire logic [7:0] flashRdData,
	input wire logic flashRdErr,
	output logic idleLock
);

	// -------------------------------------------------------------------
	// types and state
	// -------------------------------------------------------------------
	typedef enum logic [2:0] {
		S_MATCH1,
		S_MATCH2,
		S_CMD,
		S_SUMRUN,
		S_SUMSEND,
		S_IDSEND,
		S_ERR,
		S_LOCK
	} bssr_state_t;

	bssr_state_t state_q, state_d;
	logic [4:0] idx_q, idx_d;
	logic [7:0] acc_q, acc_d;
	logic [7:0] errCode_q, errCode_d;
	logic baudLock_q, baudLock_d;
	logic rxReady_q, rxReady_d;
	logic idleLock_q, idleLock_d;
	logic sumErr_q, sumErr_d;
	logic [15:0] sumVal_q, sumVal_d;
	logic sumBlank_q, sumBlank_d;

	logic pushValid;
	logic [7:0] pushData;
	logic fifoInReady, fifoRoom2;
	logic sumStart, sumDone, sumAllErased;
	logic [15:0] sumOut;
	logic take;
	logic [7:0] idByte;

	// -------------------------------------------------------------------
	// identification table
	// -------------------------------------------------------------------
	function automatic logic [7:0] id_table(input logic [4:0] i);
		case (i)
			5'h00: id_table = ID_START_MARK; // see R12
			5'h01: id_table = ID_DATA_COUNT; // see R12
			5'h02: id_table = ID_ADDR_LEN; // see R13
			5'h03: id_table = ID_RSVD_FIRST; // see R13
			5'h04, 5'h05, 5'h06: id_table = ID_RSVD; // see R13
			5'h07: id_table = ID_ROM_SIZE; // see R14
			5'h08: id_table = ID_ROM_BLOCKS; // see R14
			5'h09: id_table = ROM_FIRST[23:16]; // see R15
			5'h0A: id_table = ROM_FIRST[15:8]; // see R15
			5'h0B: id_table = ROM_FIRST[7:0]; // see R15
			5'h0C: id_table = ROM_LAST[23:16]; // see R16
			5'h0D: id_table = ROM_LAST[15:8];
			5'h0E: id_table = ROM_LAST[7:0];
			5'h0F: id_table = RAM_FIRST[23:16];
			5'h10: id_table = RAM_FIRST[15:8];
			5'h11: id_table = RAM_FIRST[7:0];
			5'h12: id_table = RAM_LAST[23:16];
			5'h13: id_table = RAM_LAST[15:8];
			5'h14: id_table = RAM_LAST[7:0];
			default: id_table = 8'h00;
		endcase
	endfunction : id_table

	function automatic logic accepts(input bssr_state_t s);
		accepts = (s == S_MATCH1) || (s == S_MATCH2) || (s == S_CMD);
	endfunction : accepts

	// -------------------------------------------------------------------
	// command sequencer
	// -------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		acc_d = acc_q;
		errCode_d = errCode_q;
		baudLock_d = baudLock_q;
		idleLock_d = idleLock_q;
		sumErr_d = sumErr_q;
		sumVal_d = sumVal_q;
		sumBlank_d = sumBlank_q;
		pushValid = 1'b0;
		pushData = 8'h00;
		sumStart = 1'b0;
		take = rxValid && rxReady_q;
		idByte = id_table(idx_q);
		case (state_q)
			S_MATCH1: begin
				if (take && rxBaudOk && (rxData == MATCH1_A || rxData == MATCH1_B)) begin
					pushValid = 1'b1; // see R1
					pushData = rxData;
					baudLock_d = 1'b1; // see R3
					state_d = S_MATCH2;
				end
			end
			S_MATCH2: begin
				// a wrong byte is swallowed without any answer
				if (take && (rxData == MATCH2_A || rxData == MATCH2_B)) begin
					pushValid = 1'b1; // see R2
					pushData = rxData;
					state_d = S_CMD;
				end
			end
			S_CMD: begin
				if (take) begin
					idx_d = '0;
					if (flashSecure) begin
						state_d = S_LOCK; // see R9
					end else if (rxOverrun) begin
						errCode_d = ERR_OVR; // see R5
						state_d = S_ERR;
					end else if (rxCommErr) begin
						errCode_d = ERR_COMM; // see R5
						state_d = S_ERR;
					end else if (rxData == CMD_SUM) begin
						sumStart = 1'b1; // see R4
						sumErr_d = 1'b0;
						state_d = S_SUMRUN;
					end else if (rxData == CMD_ID) begin
						pushValid = 1'b1; // see R11
						pushData = rxData;
						acc_d = '0;
						state_d = S_IDSEND;
					end else begin
						errCode_d = ERR_CMD; // see R11
						state_d = S_ERR;
					end
				end
			end
			S_SUMRUN: begin
				if (flashRdErr) begin
					sumErr_d = 1'b1;
				end
				if (sumDone) begin
					sumVal_d = sumOut;
					sumBlank_d = sumAllErased;
					state_d = S_SUMSEND;
				end
			end
			S_SUMSEND: begin
				if (fifoInReady) begin
					pushValid = 1'b1;
					idx_d = idx_q + 5'h01;
					case (idx_q)
						5'h00: pushData = sumBlank_q ? SUM_BLANK : SUM_USED; // see R6
						5'h01: pushData = sumVal_q[15:8]; // see R7
						default: pushData = sumVal_q[7:0]; // see R7
					endcase
					// an error ends the answer after the status byte
					if (idx_q == 5'h02 || sumErr_q) begin
						state_d = S_CMD; // see R8
					end
				end
			end
			S_IDSEND: begin
				if (fifoInReady) begin
					pushValid = 1'b1;
					idx_d = idx_q + 5'h01;
					if (idx_q == ID_LEN) begin
						pushData = 8'h00 - acc_q; // see R17
						state_d = S_CMD; // see R18
					end else begin
						pushData = idByte;
						if (idx_q >= ID_SUM_FIRST) begin
							acc_d = acc_q + idByte; // see R17
						end
					end
				end
			end
			S_ERR: begin
				if (fifoInReady) begin
					pushValid = 1'b1; // see R5
					pushData = errCode_q;
					idx_d = idx_q + 5'h01;
					if (idx_q == 5'(ERR_REPEAT - 2'h1)) begin
						state_d = S_LOCK; // see R5
					end
				end
			end
			S_LOCK: begin
				idleLock_d = 1'b1;
			end
			default: begin
				state_d = S_LOCK;
			end
		endcase
		// password failure and a link error in the password phase win over the next state, the byte push and the sum start
		if (pwFail || (pwPhase && rxCommErr)) begin
			state_d = S_LOCK; // see R9 see R10
			pushValid = 1'b0;
			sumStart = 1'b0;
		end
		if (state_d == S_LOCK) begin
			idleLock_d = 1'b1;
		end
		rxReady_d = accepts(state_d) && fifoRoom2;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= S_MATCH1;
			idx_q <= '0;
			acc_q <= '0;
			errCode_q <= '0;
			baudLock_q <= 1'b0;
			rxReady_q <= 1'b0;
			idleLock_q <= 1'b0;
			sumErr_q <= 1'b0;
			sumVal_q <= '0;
			sumBlank_q <= 1'b0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
			acc_q <= acc_d;
			errCode_q <= errCode_d;
			baudLock_q <= baudLock_d;
			rxReady_q <= rxReady_d;
			idleLock_q <= idleLock_d;
			sumErr_q <= sumErr_d;
			sumVal_q <= sumVal_d;
			sumBlank_q <= sumBlank_d;
		end
	end

	// -------------------------------------------------------------------
	// sub blocks
	// -------------------------------------------------------------------
	bssr_flash_sum u_sum (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start(sumStart),
		.rdAddr(flashRdAddr),
		.rdEn(flashRdEn),
		.rdData(flashRdData),
		.done(sumDone),
		.sum(sumOut),
		.allErased(sumAllErased)
	);

	// the fifo output stage is a register, so tx outputs are flop driven
	bssr_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(TX_DEPTH)
	) u_txq (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.inValid(pushValid),
		.inData(pushData),
		.inReady(fifoInReady),
		.inRoom2(fifoRoom2),
		.outValid(txValid),
		.outData(txData),
		.outReady(txReady)
	);

	assign rxReady = rxReady_q;
	assign baudLock = baudLock_q;
	assign idleLock = idleLock_q;

endmodule : bssr_responder

/* File: rtl/bssr_pkg.sv */
// constants shared by the boot serial sum and id responder
// assumes a byte-level framer outside that handles bits and baud timing
package bssr_pkg;

	// -------------------------------------------------------------------
	// matching, command and answer codes
	// -------------------------------------------------------------------
	localparam logic [7:0] MATCH1_A = 8'h86;
	localparam logic [7:0] MATCH1_B = 8'h30;
	localparam logic [7:0] MATCH2_A = 8'h79;
	localparam logic [7:0] MATCH2_B = 8'hCF;
	localparam logic [7:0] CMD_SUM = 8'h90;
	localparam logic [7:0] CMD_ID = 8'hC0;
	localparam logic [7:0] ERR_CMD = 8'hA1;
	localparam logic [7:0] ERR_COMM = 8'hA3;
	localparam logic [7:0] ERR_OVR = 8'h63;
	localparam logic [1:0] ERR_REPEAT = 2'h3;
	localparam logic [7:0] SUM_BLANK = 8'hAA;
	localparam logic [7:0] SUM_USED = 8'h55;
	localparam logic [7:0] ERASED = 8'hFF;

	// -------------------------------------------------------------------
	// identification answer
	// -------------------------------------------------------------------
	localparam logic [7:0] ID_START_MARK = 8'h3A;
	localparam logic [7:0] ID_DATA_COUNT = 8'h13;
	localparam logic [7:0] ID_ADDR_LEN = 8'h03;
	localparam logic [7:0] ID_RSVD_FIRST = 8'hFD;
	localparam logic [7:0] ID_RSVD = 8'h00;
	localparam logic [7:0] ID_ROM_SIZE = 8'h80;
	localparam logic [7:0] ID_ROM_BLOCKS = 8'h01;
	localparam logic [23:0] ROM_FIRST = 24'h008000;
	localparam logic [23:0] ROM_LAST = 24'h00FFFF;
	localparam logic [23:0] RAM_FIRST = 24'h000060;
	localparam logic [23:0] RAM_LAST = 24'h00083F;
	// bytes before the checksum byte, and index where the summed part starts
	localparam logic [4:0] ID_LEN = 5'h15;
	localparam logic [4:0] ID_SUM_FIRST = 5'h02;

	// -------------------------------------------------------------------
	// flash range covered by the sum, and buffer shape
	// -------------------------------------------------------------------
	localparam logic [15:0] FLASH_START = 16'h8000;
	localparam logic [15:0] FLASH_END = 16'hFFFF;
	localparam int BYTE_W = 8;
	localparam int TX_DEPTH = 16;

endpackage : bssr_pkg

/* File: rtl/bssr_fifo.sv */
// byte fifo with valid/ready on both sides and a registered output stage
// assumes one clock; the filler honours inReady, the drainer may stall
`timescale 1ns/100ps
module bssr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	output logic inRoom2,
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [AW:0] count_q, count_d;
	logic outValid_q, outValid_d;
	logic [WIDTH-1:0] outData_q, outData_d;
	logic push, pop;

	// -------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------
	always_comb begin
		inReady = (count_q != DEPTH[AW:0]);
		// room for two lets a registered ready upstream stay honest
		inRoom2 = (count_q < (DEPTH[AW:0] - (AW+1)'(1)));
		push = inValid && inReady;
		pop = (count_q != '0) && (!outValid_q || outReady);
		wrPtr_d = push ? wrPtr_q + AW'(1) : wrPtr_q;
		rdPtr_d = pop ? rdPtr_q + AW'(1) : rdPtr_q;
		count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
		outValid_d = pop ? 1'b1 : (outReady ? 1'b0 : outValid_q);
		outData_d = pop ? mem[rdPtr_q] : outData_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
			outValid_q <= 1'b0;
			outData_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
			outValid_q <= outValid_d;
			outData_q <= outData_d;
		end
	end

	// storage needs no reset; only valid entries are ever read
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	assign outValid = outValid_q;
	assign outData = outData_q;

endmodule : bssr_fifo

/* File: rtl/bssr_flash_sum.sv */
// walks the covered flash range and forms a 16-bit byte sum
// assumes flash read data is valid one clock after the address
`timescale 1ns/100ps
module bssr_flash_sum
	import bssr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic start,
	output logic [15:0] rdAddr,
	output logic rdEn,
	input wire logic [7:0] rdData,
	output logic done,
	output logic [15:0] sum,
	output logic allErased
);
	logic busy_q, busy_d, pend_q, pend_d, done_q, done_d, last_q, last_d;
	logic allErased_q, allErased_d;
	logic [15:0] addr_q, addr_d, acc_q, acc_d;

	// -------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------
	always_comb begin
		busy_d = busy_q;
		addr_d = addr_q;
		acc_d = acc_q;
		allErased_d = allErased_q;
		pend_d = busy_q;
		last_d = busy_q && (addr_q == FLASH_END);
		done_d = 1'b0;
		if (start && !busy_q) begin
			busy_d = 1'b1;
			addr_d = FLASH_START;
			acc_d = '0;
			allErased_d = 1'b1;
			pend_d = 1'b0;
		end else if (busy_q) begin
			if (addr_q == FLASH_END) begin
				busy_d = 1'b0;
			end else begin
				addr_d = addr_q + 16'h0001;
			end
		end
		if (pend_q) begin
			acc_d = acc_q + {8'h00, rdData}; // see R19
			if (rdData != ERASED) begin
				allErased_d = 1'b0; // see R6
			end
			done_d = last_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			pend_q <= 1'b0;
			last_q <= 1'b0;
			done_q <= 1'b0;
			addr_q <= '0;
			acc_q <= '0;
			allErased_q <= 1'b1;
		end else begin
			busy_q <= busy_d;
			pend_q <= pend_d;
			last_q <= last_d;
			done_q <= done_d;
			addr_q <= addr_d;
			acc_q <= acc_d;
			allErased_q <= allErased_d;
		end
	end

	assign rdAddr = addr_q;
	assign rdEn = busy_q;
	assign done = done_q;
	assign sum = acc_q;
	assign allErased = allErased_q;

endmodule : bssr_flash_sum

/* File: sim/bssr_checker.sv */
// port checker for the boot serial responder
// assumes one clock; bound onto every bssr_responder
`timescale 1ns/100ps
module bssr_checker
	import bssr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	input wire logic rxBaudOk,
	input wire logic rxCommErr,
	input wire logic pwPhase,
	input wire logic pwFail,
	input wire logic rxReady,
	input wire logic baudLock,
	input wire logic txValid,
	input wire logic [7:0] txData,
	input wire logic txReady,
	input wire logic [15:0] flashRdAddr,
	input wire logic flashRdEn,
	input wire logic idleLock
);
	logic takeM1;
	// a lock request that cycle overrides the first-byte take
	assign takeM1 = rxValid && rxReady && rxBaudOk && (rxData == 8'h86 || rxData == 8'h30)
		&& !pwFail && !(pwPhase && rxCommErr);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !txValid && !idleLock && !baudLock)
		else $error("outputs busy after reset");
	match_lock_a: assert property (takeM1 |=> baudLock)
		else $error("first byte did not lock baud");
	lock_keep_a: assert property (baudLock |=> baudLock)
		else $error("measured baud dropped");
	tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
		else $error("tx byte changed before taken");
	pw_lock_a: assert property (pwFail |-> ##[1:2] idleLock)
		else $error("password failure did not idle");
	comm_lock_a: assert property (pwPhase && rxCommErr |-> ##[1:2] idleLock)
		else $error("password link error did not idle");
	idle_stay_a: assert property (idleLock |=> idleLock && !rxReady)
		else $error("idle left before reset");
	sum_quiet_a: assert property (flashRdEn |-> !txValid)
		else $error("byte sent during sum walk");
	walk_start_a: assert property ($rose(flashRdEn) |-> flashRdAddr == 16'h8000)
		else $error("sum walk start wrong");
	walk_step_a: assert property (flashRdEn && $past(flashRdEn) |-> flashRdAddr == $past(flashRdAddr) + 16'h0001)
		else $error("sum walk skipped");
	walk_end_a: assert property ($fell(flashRdEn) |-> $past(flashRdAddr) == 16'hFFFF)
		else $error("sum walk end wrong");
	cover property (takeM1);
	cover property ($fell(flashRdEn));
	cover property ($rose(idleLock));
endmodule : bssr_checker

bind bssr_responder bssr_checker chk (.sys_clk(sys_clk), .rst_n(rst_n), .rxValid(rxValid),
	.rxData(rxData), .rxBaudOk(rxBaudOk), .rxCommErr(rxCommErr), .pwPhase(pwPhase),
	.pwFail(pwFail), .rxReady(rxReady), .baudLock(baudLock), .txValid(txValid),
	.txData(txData), .txReady(txReady), .flashRdAddr(flashRdAddr), .flashRdEn(flashRdEn),
	.idleLock(idleLock));

/* File: sim/bssr_host_model.sv */
// controller-side model: offers bytes to the responder and takes its answers
// assumes the bench seeds $urandom and calls put from one process only
`timescale 1ns/100ps
module bssr_host_model (
	input wire logic sys_clk,
	input wire logic rxReady,
	output logic rxValid,
	output logic [7:0] rxData,
	output logic rxBaudOk,
	output logic rxCommErr,
	output logic rxOverrun,
	output logic txReady
);
	initial begin
		rxValid = 1'b0;
		rxData = 8'hA5;
		rxBaudOk = 1'b0;
		rxCommErr = 1'b0;
		rxOverrun = 1'b0;
		txReady = 1'b0;
	end
	// random stalls so the answer fifo backs up
	always @(posedge sys_clk) begin
		txReady <= ($urandom_range(3) != 0);
	end
	task automatic put(input logic [7:0] b, input logic ok, input logic ce, input logic ov);
		@(posedge sys_clk);
		rxValid <= 1'b1;
		rxData <= b;
		rxBaudOk <= ok;
		rxCommErr <= ce;
		rxOverrun <= ov;
		@(posedge sys_clk);
		while (rxReady !== 1'b1) @(posedge sys_clk);
		// released data line shows the inverse, not a stale copy
		rxValid <= 1'b0;
		rxData <= ~b;
		rxBaudOk <= 1'b0;
		rxCommErr <= 1'b0;
		rxOverrun <= 1'b0;
	endtask : put
endmodule : bssr_host_model

/* File: sim/tb_boot_serial_sum_and_id_responder.sv */
// bench for the boot serial responder with a controller model and flash model
// assumes the checker is bound by its own file
`timescale 1ns/100ps
module tb_boot_serial_sum_and_id_responder;
	import bssr_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic rxValid, rxBaudOk, rxCommErr, rxOverrun, rxReady, baudLock, txValid, txReady;
	logic [7:0] rxData, txData;
	logic flashSecure = 1'b0, pwPhase = 1'b0, pwFail = 1'b0, flashRdErr = 1'b0, blank = 1'b1;
	logic flashRdEn, idleLock;
	logic [7:0] flashRdData = 8'hFF, spot = 8'h00;
	logic [15:0] flashRdAddr;
	logic [7:0] expQ[$];
	logic [7:0] idTab[21] = '{8'h3A, 8'h13, 8'h03, 8'hFD, 8'h00, 8'h00, 8'h00, 8'h80, 8'h01, 8'h00, 8'h80,
		8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h60, 8'h00, 8'h08, 8'h3F};
	logic [7:0] errs[3] = '{8'h63, 8'hA3, 8'hA1};
	logic [7:0] cmds[3] = '{8'h90, 8'hC0, 8'h11};
	int mismatches = 0, checks = 0, cycles = 0;

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	bssr_host_model host (.sys_clk(sys_clk), .rxReady(rxReady), .rxValid(rxValid), .rxData(rxData),
		.rxBaudOk(rxBaudOk), .rxCommErr(rxCommErr), .rxOverrun(rxOverrun), .txReady(txReady));
	bssr_responder dut (.sys_clk(sys_clk), .rst_n(rst_n), .rxValid(rxValid), .rxData(rxData),
		.rxBaudOk(rxBaudOk), .rxCommErr(rxCommErr), .rxOverrun(rxOverrun), .rxReady(rxReady),
		.baudLock(baudLock), .txValid(txValid), .txData(txData), .txReady(txReady),
		.flashSecure(flashSecure), .pwPhase(pwPhase), .pwFail(pwFail), .flashRdAddr(flashRdAddr),
		.flashRdEn(flashRdEn), .flashRdData(flashRdData), .flashRdErr(flashRdErr), .idleLock(idleLock));
	// flash: erased except one spot byte when not blank
	always @(posedge sys_clk) begin
		flashRdData <= (blank || flashRdAddr != 16'h9000) ? 8'hFF : spot;
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up
	task automatic drain(input int n);
		for (int i = 0; i < n && expQ.size() != 0; i++) @(posedge sys_clk);
		check("answer count", 16'(expQ.size()), 16'h0000);
		expQ.delete();
		// let any stray byte surface
		repeat (10) @(posedge sys_clk);
	endtask : drain
	task automatic restart();
		@(posedge sys_clk);
		rst_n <= 1'b0;
		flashRdErr <= 1'b0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
	endtask : restart
	task automatic open(input logic [7:0] m1, input logic [7:0] m2);
		expQ.push_back(m1);
		host.put(m1, 1'b1, 1'b0, 1'b0);
		expQ.push_back(m2);
		host.put(m2, 1'b1, 1'b0, 1'b0);
		drain(60);
		check("baudLock", 16'(baudLock), 16'h0001);
	endtask : open
	// err holds the flash read error up through the walk: only the status byte may come back
	task automatic sum(input logic [7:0] st, input logic [15:0] s, input logic err);
		expQ.push_back(st);
		if (!err) begin
			expQ.push_back(s[15:8]);
			expQ.push_back(s[7:0]);
		end
		flashRdErr <= err;
		host.put(8'h90, 1'b1, 1'b0, 1'b0);
		drain(34000);
	endtask : sum

	// ---------------------------------------------------------------
	// answer monitor and timeout
	// ---------------------------------------------------------------
	always @(posedge sys_clk) begin
		cycles++;
		if (rst_n && txValid === 1'b1 && txReady === 1'b1) begin
			if (expQ.size() == 0) begin
				// a byte nobody asked for: flagged with a marker bit so it can never match
				check("unasked txData", {8'h01, txData}, 16'h0000);
			end else begin
				check("txData", {8'h00, txData}, {8'h00, expQ.pop_front()});
			end
		end
		if (cycles == 90000) begin
			mismatches++;
			wrap_up();
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [7:0] acc;
		void'($urandom(29));
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		host.put(8'h30, 1'b0, 1'b0, 1'b0);
		drain(10);
		check("baudLock", 16'(baudLock), 16'h0000);
		expQ.push_back(8'h86);
		host.put(8'h86, 1'b1, 1'b0, 1'b0);
		host.put(8'h11, 1'b1, 1'b0, 1'b0);
		drain(60);
		open_tail: begin
			expQ.push_back(8'h79);
			host.put(8'h79, 1'b1, 1'b0, 1'b0);
			drain(60);
		end
		acc = 8'h00;
		expQ.push_back(8'hC0);
		foreach (idTab[i]) begin
			expQ.push_back(idTab[i]);
			if (i >= 2) acc = acc + idTab[i];
		end
		expQ.push_back(8'h00 - acc);
		host.put(8'hC0, 1'b1, 1'b0, 1'b0);
		drain(600);
		spot <= 8'($urandom_range(254));
		blank <= 1'b0;
		@(posedge sys_clk);
		sum(8'h55, 16'h8000 - 16'h00FF + {8'h00, spot}, 1'b0);
		blank <= 1'b1;
		sum(8'hAA, 16'h8000, 1'b1);
		for (int k = 0; k < 3; k++) begin
			restart();
			open(8'h30, 8'hCF);
			repeat (3) expQ.push_back(errs[k]);
			host.put(cmds[k], 1'b1, k == 1, k == 0);
			drain(80);
			check("idleLock", 16'(idleLock), 16'h0001);
		end
		restart();
		open(8'h86, 8'h79);
		flashSecure <= 1'b1;
		host.put(8'hC0, 1'b1, 1'b0, 1'b0);
		drain(20);
		check("idleLock", 16'(idleLock), 16'h0001);
		flashSecure <= 1'b0;
		restart();
		open(8'h86, 8'h79);
		pwFail <= 1'b1;
		@(posedge sys_clk);
		pwFail <= 1'b0;
		drain(5);
		check("idleLock", 16'(idleLock), 16'h0001);
		restart();
		open(8'h30, 8'h79);
		pwPhase <= 1'b1;
		host.put(8'hC0, 1'b1, 1'b1, 1'b0);
		drain(20);
		check("idleLock", 16'(idleLock), 16'h0001);
		pwPhase <= 1'b0;
		wrap_up();
	end
endmodule : tb_boot_serial_sum_and_id_responder
